// ===== hdl/fak_pkg.sv
// shared constants, types and register map for the field address / keypad controller
package fak_pkg;
    localparam longint unsigned CLK_HZ = 25_000_000;
    // times as specified, in their own units
    localparam longint unsigned SELFTEST_S = 30;
    localparam longint unsigned HOLD_MS = 1000;
    localparam longint unsigned CHORD_MS = 5000;
    localparam longint unsigned IDLE_MIN = 60;
    localparam longint unsigned REPEAT_MS = 100;
    // derived cycle counts
    localparam longint unsigned SELFTEST_CYC = SELFTEST_S * CLK_HZ;
    localparam longint unsigned HOLD_CYC = HOLD_MS * CLK_HZ / 1000;
    localparam longint unsigned CHORD_CYC = CHORD_MS * CLK_HZ / 1000;
    localparam longint unsigned IDLE_CYC = IDLE_MIN * 60 * CLK_HZ;
    localparam longint unsigned REPEAT_CYC = REPEAT_MS * CLK_HZ / 1000;

    // station address
    localparam logic [7:0] ADDR_SW_LIMIT = 8'h7e;
    localparam logic [6:0] ADDR_MAX = 7'h7e;
    localparam logic [6:0] ADDR_RESET = 7'h7e;
    localparam logic [7:0] HUNDREDS = 8'h64;
    localparam logic [3:0] DIGIT_MAX = 4'h9;
    // switch stages start on digits above nine, which decode as "defer to software"
    localparam logic [12:0] PIN_SYNC_RESET = 13'h1ff0;

    // output status byte values
    localparam logic [7:0] STATUS_FAULT = 8'h0f;
    localparam logic [7:0] STATUS_GOOD = 8'h80;

    // register offsets (byte addresses)
    localparam int AW = 5;
    localparam logic [AW-1:0] A_SWADDR = 5'h00;
    localparam logic [AW-1:0] A_STATUS = 5'h04;
    localparam logic [AW-1:0] A_IRQ_ST = 5'h08;
    localparam logic [AW-1:0] A_IRQ_MSK = 5'h0c;
    localparam logic [AW-1:0] A_SAVED = 5'h10;
    localparam logic [4:0] IRQ_MSK_RESET = 5'h00;
    localparam logic [7:0] SAVED_RESET = 8'h00;

    // key indices
    localparam int K_OK = 0;
    localparam int K_ESC = 1;
    localparam int K_CUR = 2;
    localparam int K_INC = 3;
    localparam logic [1:0] VIEW_LAST = 2'h2;

    typedef enum logic [1:0] {MD_MEAS, MD_MENU, MD_EDIT} fak_mode_e;

    typedef struct packed {
        logic inc;
        logic cur;
        logic esc;
        logic ok;
    } fak_key_s;

    typedef struct packed {
        logic hund;
        logic [3:0] tens;
        logic [3:0] units;
    } fak_sw_s;

    typedef struct packed {
        logic addr_chg;
        logic timeout;
        logic chord;
        logic key;
        logic selftest;
    } fak_ev_s;

    typedef struct packed {
        logic [2:0] menu_item;
        logic lang_english;
        fak_mode_e mode;
        logic [1:0] view;
        logic selftest_done;
        logic [6:0] station_addr;
    } fak_status_s;
endpackage

// ===== hdl/fak_key.sv
// one key: press pulse, and step pulses with auto-repeat after a long hold
`timescale 1ns/1ps
module fak_key #(
    parameter int unsigned HOLD = 25_000_000,
    parameter int unsigned RPT = 2_500_000
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic lvl,
    output logic press,
    output logic step
);
    localparam int CW = $clog2(HOLD + 1);
    logic [CW-1:0] cnt;
    logic prev;
    logic rep;
    wire hold_hit = cnt == CW'(HOLD - 1);
    wire rpt_hit = cnt == CW'(RPT - 1);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= '0;
            prev <= 1'b0;
            rep <= 1'b0;
            press <= 1'b0;
            step <= 1'b0;
        end else if (ce) begin
            prev <= lvl;
            press <= lvl & ~prev;
            step <= 1'b0;
            cnt <= cnt + 1'b1;
            if (!lvl) begin
                cnt <= '0;
                rep <= 1'b0;
            end else if (!prev) begin
                step <= 1'b1;
                cnt <= '0;
            end else if ((!rep && hold_hit) || (rep && rpt_hit)) begin
                // held past the hold time: keep stepping at the repeat rate
                rep <= 1'b1;
                step <= 1'b1;
                cnt <= '0;
            end
        end
    end
endmodule // fak_key

// ===== hdl/fak_ctrl.sv
// station address selection, switch-on self-test and keypad control
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module fak_ctrl
    import fak_pkg::*;
#(
    parameter longint unsigned ST_CYC = fak_pkg::SELFTEST_CYC,
    parameter longint unsigned HOLD_C = fak_pkg::HOLD_CYC,
    parameter longint unsigned CHORD_C = fak_pkg::CHORD_CYC,
    parameter longint unsigned IDLE_C = fak_pkg::IDLE_CYC,
    parameter longint unsigned RPT_C = fak_pkg::REPEAT_CYC,
    parameter int MW = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [fak_pkg::AW-1:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rd_data,
    output logic irq,
    input wire fak_pkg::fak_key_s key_pin,
    input wire fak_pkg::fak_sw_s sw_pin,
    input wire logic [MW-1:0] meas_in,
    output logic [MW-1:0] meas_out,
    output logic [7:0] status_byte,
    output logic sig_fault,
    output logic [6:0] station_addr,
    output logic [1:0] disp_view,
    output fak_pkg::fak_mode_e disp_mode,
    output logic [2:0] menu_item,
    output logic [7:0] edit_val,
    output logic lang_english
);
    import fak_pkg::*;
    localparam int SW = $clog2(ST_CYC + 1);
    localparam int CHW = $clog2(CHORD_C + 1);
    localparam int IW = $clog2(IDLE_C + 1);

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: first stage feeds only the second
    logic [12:0] sync1;
    logic [12:0] sync2;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            // an all-zero switch word would decode as address 0 for two cycles
            // after reset and flag a false address change
            sync1 <= PIN_SYNC_RESET;
            sync2 <= PIN_SYNC_RESET;
        end else if (ce) begin
            sync1 <= {sw_pin, key_pin};
            sync2 <= sync1;
        end
    end
    fak_key_s keys;
    fak_sw_s sw;
    assign keys = sync2[3:0];
    assign sw = sync2[12:4];

    ////////////////////////////////////////////////////////////////////////////////
    // station address
    logic [6:0] sw_addr;
    wire [7:0] tens_x10 = {1'b0, sw.tens, 3'h0} + {3'h0, sw.tens, 1'b0};
    wire [7:0] sw_val = (sw.hund ? HUNDREDS : 8'h00) + tens_x10 + {4'h0, sw.units};
    // a digit above nine is not a real setting: treat as "defer to software"
    wire sw_bad = (sw.tens > DIGIT_MAX) || (sw.units > DIGIT_MAX);
    wire sw_hw = !sw_bad && (sw_val < ADDR_SW_LIMIT);
    wire [6:0] next_addr = sw_hw ? sw_val[6:0] : sw_addr;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            station_addr <= ADDR_RESET;
        end else if (ce) begin
            station_addr <= next_addr;
        end
    end

    chk_hw_addr: assert property (@(posedge clk) disable iff (!nrst)
        ce && sw_hw |=> station_addr == $past(sw_val[6:0]))
        else $error("switch address not applied");
    chk_sw_addr: assert property (@(posedge clk) disable iff (!nrst)
        ce && !sw_hw |=> station_addr == $past(sw_addr))
        else $error("software address not applied");
    chk_addr_range: assert property (@(posedge clk) disable iff (!nrst)
        station_addr <= ADDR_MAX && sw_addr <= ADDR_MAX)
        else $error("station address out of range");

    ////////////////////////////////////////////////////////////////////////////////
    // switch-on self-test
    logic [SW-1:0] st_cnt;
    logic st_done;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_cnt <= '0;
            st_done <= 1'b0;
            sig_fault <= 1'b1;
            status_byte <= STATUS_FAULT;
            meas_out <= '0;
        end else if (ce) begin
            if (!st_done) begin
                st_cnt <= st_cnt + 1'b1;
            end
            if (st_cnt == SW'(ST_CYC - 1)) begin
                st_done <= 1'b1;
            end
            // the measured value is held back until the self-test is over
            sig_fault <= !st_done;
            status_byte <= st_done ? STATUS_GOOD : STATUS_FAULT;
            meas_out <= st_done ? meas_in : '0;
        end
    end

    chk_fault_test: assert property (@(posedge clk) disable iff (!nrst)
        ce && !st_done |=> sig_fault && status_byte == STATUS_FAULT && meas_out == '0)
        else $error("real value shown during self-test");
    chk_test_end: assert property (@(posedge clk) disable iff (!nrst)
        ce && st_done |=> !sig_fault && status_byte == STATUS_GOOD)
        else $error("fault still shown after self-test");

    ////////////////////////////////////////////////////////////////////////////////
    // keys
    logic [3:0] press;
    logic [3:0] step;
    for (genvar k = 0; k < 4; k++) begin : g_key
        fak_key #(.HOLD(32'(HOLD_C)), .RPT(32'(RPT_C))) u_key (
            .clk(clk),
            .nrst(nrst),
            .ce(ce),
            .lvl(keys[k]),
            .press(press[k]),
            .step(step[k])
        );
    end

    logic [CHW-1:0] chord_cnt;
    logic [IW-1:0] idle_cnt;
    wire chord_on = keys.ok && keys.esc;
    wire chord_hit = chord_on && chord_cnt == CHW'(CHORD_C - 1);
    wire idle_hit = idle_cnt == IW'(IDLE_C - 1);
    wire any_press = |press;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            chord_cnt <= '0;
            idle_cnt <= '0;
        end else if (ce) begin
            // both counters saturate so each hit is a single pulse
            if (!chord_on) begin
                chord_cnt <= '0;
            end else if (chord_cnt != CHW'(CHORD_C)) begin
                chord_cnt <= chord_cnt + 1'b1;
            end
            if (any_press) begin
                idle_cnt <= '0;
            end else if (idle_cnt != IW'(IDLE_C)) begin
                idle_cnt <= idle_cnt + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // menu state
    logic [7:0] saved;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            disp_mode <= MD_MEAS;
            disp_view <= '0;
            menu_item <= '0;
            edit_val <= '0;
            saved <= SAVED_RESET;
            lang_english <= 1'b1;
        end else if (ce) begin
            if (idle_hit) begin
                disp_mode <= MD_MEAS;
                edit_val <= saved;
            end else if (chord_hit) begin
                disp_mode <= MD_MENU;
                menu_item <= '0;
                lang_english <= 1'b1;
                edit_val <= saved;
            end else begin
                case (disp_mode)
                    MD_MEAS: begin
                        if (press[K_OK]) begin
                            disp_mode <= MD_MENU;
                        end else if (press[K_CUR]) begin
                            disp_view <= (disp_view == VIEW_LAST) ? 2'h0 : disp_view + 2'h1;
                        end
                    end
                    MD_MENU: begin
                        if (press[K_ESC]) begin
                            disp_mode <= MD_MEAS;
                        end else if (press[K_OK]) begin
                            disp_mode <= MD_EDIT;
                            edit_val <= saved;
                        end else if (step[K_CUR]) begin
                            menu_item <= menu_item + 3'h1;
                        end
                    end
                    MD_EDIT: begin
                        if (press[K_ESC]) begin
                            // abort: unconfirmed value is thrown away
                            disp_mode <= MD_MENU;
                            edit_val <= saved;
                        end else if (press[K_OK]) begin
                            disp_mode <= MD_MENU;
                            saved <= edit_val;
                        end else if (step[K_INC]) begin
                            edit_val <= edit_val + 8'h01;
                        end
                    end
                    default: begin
                        disp_mode <= MD_MEAS;
                    end
                endcase
            end
        end
    end

    wire keys_only = ce && !idle_hit && !chord_hit;
    chk_view_cycle: assert property (@(posedge clk) disable iff (!nrst)
        keys_only && disp_mode == MD_MEAS && !press[K_OK] && press[K_CUR]
        |=> disp_view == (($past(disp_view) == VIEW_LAST) ? 2'h0 : $past(disp_view) + 2'h1))
        else $error("display view did not advance");
    chk_chord_menu: assert property (@(posedge clk) disable iff (!nrst)
        ce && !idle_hit && chord_hit |=> disp_mode == MD_MENU && lang_english)
        else $error("chord did not return to main menu");
    chk_idle_return: assert property (@(posedge clk) disable iff (!nrst)
        ce && idle_hit |=> disp_mode == MD_MEAS && edit_val == saved)
        else $error("idle timeout did not return to measurement");
    chk_esc_abort: assert property (@(posedge clk) disable iff (!nrst)
        keys_only && disp_mode == MD_EDIT && press[K_ESC]
        |=> disp_mode == MD_MENU && saved == $past(saved))
        else $error("escape did not abort edit");
    chk_inc_step: assert property (@(posedge clk) disable iff (!nrst)
        keys_only && disp_mode == MD_EDIT && !press[K_ESC] && !press[K_OK] && step[K_INC]
        |=> edit_val == $past(edit_val) + 8'h01)
        else $error("increment did not step value");
    chk_menu_open: assert property (@(posedge clk) disable iff (!nrst)
        keys_only && disp_mode == MD_MEAS && press[K_OK] |=> disp_mode == MD_MENU)
        else $error("confirm did not open the menu");
    chk_menu_up: assert property (@(posedge clk) disable iff (!nrst)
        keys_only && disp_mode == MD_MENU && press[K_ESC] |=> disp_mode == MD_MEAS)
        else $error("escape did not leave the menu");
    chk_ok_save: assert property (@(posedge clk) disable iff (!nrst)
        keys_only && disp_mode == MD_EDIT && !press[K_ESC] && press[K_OK]
        |=> disp_mode == MD_MENU && saved == $past(edit_val))
        else $error("confirm did not save the edited value");

    ////////////////////////////////////////////////////////////////////////////////
    // register port and interrupt
    fak_ev_s ev;
    logic [4:0] irq_st;
    logic [4:0] irq_msk;
    logic [6:0] addr_q;
    fak_status_s stat;
    assign ev = '{addr_chg: addr_q != station_addr, timeout: idle_hit, chord: chord_hit,
        key: any_press, selftest: ce && st_cnt == SW'(ST_CYC - 1)};
    assign stat = '{menu_item: menu_item, lang_english: lang_english, mode: disp_mode,
        view: disp_view, selftest_done: st_done, station_addr: station_addr};
    wire wr_sw = wr && addr == A_SWADDR;
    wire [4:0] irq_clr = (wr && addr == A_IRQ_ST) ? wr_data[4:0] : 5'h00;
    wire [31:0] rd_mux = (addr == A_SWADDR) ? {25'h0, sw_addr} :
        (addr == A_STATUS) ? {16'h0, stat} :
        (addr == A_IRQ_ST) ? {27'h0, irq_st} :
        (addr == A_IRQ_MSK) ? {27'h0, irq_msk} :
        (addr == A_SAVED) ? {24'h0, saved} : 32'h0;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sw_addr <= ADDR_RESET;
            irq_st <= '0;
            irq_msk <= IRQ_MSK_RESET;
            addr_q <= ADDR_RESET;
            rd_data <= '0;
            irq <= 1'b0;
        end else if (ce) begin
            // address 127 is not valid and is refused; only wr_data[6:0] is looked at, so higher bits are dropped
            if (wr_sw && wr_data[6:0] <= ADDR_MAX) begin
                sw_addr <= wr_data[6:0];
            end
            if (wr && addr == A_IRQ_MSK) begin
                irq_msk <= wr_data[4:0];
            end
            addr_q <= station_addr;
            // a new event wins over a clear in the same cycle
            irq_st <= (irq_st & ~irq_clr) | ev;
            irq <= |(irq_st & irq_msk);
            rd_data <= rd ? rd_mux : 32'h0;
        end
    end
endmodule // fak_ctrl

// ===== verif/fak_bus_mst.sv
// register bus master model standing in for the segment master
`timescale 1ns/1ps
module fak_bus_mst (
    input wire logic clk,
    output logic [fak_pkg::AW-1:0] addr,
    output logic [31:0] wr_data,
    output logic wr,
    output logic rd
);
    import fak_pkg::*;

    initial begin
        addr = '0;
        wr_data = '0;
        wr = 1'b0;
        rd = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one strobe cycle each; released lines are inverted so stale data never looks valid
    task automatic write_reg(input logic [AW-1:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d; // the data word for whichever register a selects
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~a;
        wr_data <= ~d;
    endtask

    task automatic read_reg(input logic [AW-1:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
    endtask
endmodule // fak_bus_mst

// ===== verif/tb_fak_ctrl.sv
// self-checking testbench for the address, self-test and keypad controller
`timescale 1ns/1ps
module tb_fak_ctrl;
    import fak_pkg::*;
    localparam longint unsigned ST = 50;
    logic clk;
    logic nrst;
    logic ce;
    logic [AW-1:0] addr;
    logic [31:0] wr_data;
    logic wr;
    logic rd;
    logic [31:0] rd_data;
    logic irq;
    fak_key_s keys;
    fak_sw_s sw;
    logic [15:0] meas_in;
    logic [15:0] meas_out;
    logic [7:0] status_byte;
    logic sig_fault;
    logic [6:0] station_addr;
    logic [1:0] disp_view;
    fak_mode_e disp_mode;
    logic [2:0] menu_item;
    logic [7:0] edit_val;
    logic lang_english;
    int n_fail = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [31:0] rnd = 32'h000011d7;
    logic [15:0] h1;
    logic [15:0] h2;
    logic [31:0] exp_q[$];
    logic pend = 1'b0;
    logic [8:0] sw_t [8] = '{9'h000, 9'h005, 9'h100, 9'h125, 9'h126, 9'h09a, 9'h099, 9'h199};
    logic [6:0] ad_t [8] = '{7'h00, 7'h05, 7'h64, 7'h7d, 7'h33, 7'h33, 7'h63, 7'h33};

    fak_ctrl #(.ST_CYC(ST), .HOLD_C(20), .CHORD_C(40), .IDLE_C(100), .RPT_C(5)) i_fak_ctrl (
        .clk(clk), .nrst(nrst), .ce(ce), .addr(addr), .wr_data(wr_data), .wr(wr), .rd(rd),
        .rd_data(rd_data), .irq(irq), .key_pin(keys), .sw_pin(sw), .meas_in(meas_in),
        .meas_out(meas_out), .status_byte(status_byte), .sig_fault(sig_fault),
        .station_addr(station_addr), .disp_view(disp_view), .disp_mode(disp_mode),
        .menu_item(menu_item), .edit_val(edit_val), .lang_english(lang_english));

    fak_bus_mst i_fak_bus_mst (.clk(clk), .addr(addr), .wr_data(wr_data), .wr(wr), .rd(rd));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction

    // the expectation is queued before the strobe, so it is there when the data lands
    task automatic rd_exp(input logic [AW-1:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        i_fak_bus_mst.read_reg(a);
    endtask

    // #1 lets the edge's register updates land before anything is sampled
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic keydrv(input logic [3:0] k, input int n);
        @(posedge clk);
        keys <= k;
        repeat (n) @(posedge clk);
        keys <= 4'h0;
        wait_cyc(8);
    endtask

    // read data stand only in the cycle after the strobe
    always @(posedge clk) begin
        if (pend) begin
            check(rd_data, exp_q.pop_front()); // oldest noted read
        end
        pend = rd;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        keys = 4'h0;
        sw = 9'h126;
        meas_in = 16'h0000;
        wait_cyc(12);
        check(station_addr, 32'h7e);
        check(status_byte, 32'h0f);
        check(meas_out, 32'h0);
        @(posedge clk);
        nrst <= 1'b1;
        wait_cyc(10);
        check(sig_fault, 32'h1);
        check(status_byte, 32'h0f);
        wait_cyc(ST);
        check(sig_fault, 32'h0);
        check(status_byte, 32'h80);
        rd_exp(A_IRQ_ST, 32'h1);
        i_fak_bus_mst.write_reg(A_IRQ_MSK, 32'h1);
        wait_cyc(3);
        check(irq, 32'h1);
        i_fak_bus_mst.write_reg(A_IRQ_ST, 32'h1);
        wait_cyc(3);
        check(irq, 32'h0);
        i_fak_bus_mst.write_reg(A_IRQ_MSK, 32'h0);
        for (int i = 0; i < 20; i++) begin
            @(posedge clk);
            if (i > 1) check(meas_out, {16'h0, h2});
            h2 = h1;
            h1 = rnd[15:0];
            meas_in <= rnd[15:0];
            rnd = xs(rnd);
        end
        $display("test self-test done");
        i_fak_bus_mst.write_reg(A_SWADDR, 32'h33);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            sw <= sw_t[i];
            wait_cyc(6);
            check(station_addr, ad_t[i]);
        end
        i_fak_bus_mst.write_reg(A_SWADDR, 32'h7f);
        rd_exp(A_SWADDR, 32'h33);
        wait_cyc(2);
        check(station_addr, 32'h33);
        i_fak_bus_mst.write_reg(A_SWADDR, 32'h7e);
        rd_exp(5'h14, 32'h0);
        check(station_addr, 32'h7e);
        $display("test address done");
        check(disp_mode, MD_MEAS);
        for (int v = 1; v < 4; v++) begin
            keydrv(4'h4, 2);
            check(disp_view, v % 3);
        end
        $display("test views done");
        keydrv(4'h1, 2);
        check(disp_mode, MD_MENU);
        keydrv(4'h1, 2);
        check(disp_mode, MD_EDIT);
        check(edit_val, 32'h0);
        keydrv(4'h8, 33);
        check(edit_val, 32'h4);
        keydrv(4'h1, 2);
        check(disp_mode, MD_MENU);
        rd_exp(A_SAVED, 32'h4);
        keydrv(4'h1, 2);
        keydrv(4'h8, 2);
        check(edit_val, 32'h5);
        keydrv(4'h2, 2);
        check(disp_mode, MD_MENU);
        rd_exp(A_SAVED, 32'h4);
        keydrv(4'h4, 2);
        check(menu_item, 32'h1);
        $display("test keys done");
        keydrv(4'h3, 45);
        check(disp_mode, MD_MENU);
        check(menu_item, 32'h0);
        check(lang_english, 32'h1);
        $display("test chord done");
        keydrv(4'h1, 2);
        keydrv(4'h8, 2);
        check(edit_val, 32'h5);
        wait_cyc(110);
        check(disp_mode, MD_MEAS);
        check(edit_val, 32'h4);
        rd_exp(A_STATUS, 32'h10fe);
        rd_exp(A_IRQ_ST, 32'h1e);
        wait_cyc(3);
        $display("test idle done");
        give_verdict();
    end
endmodule // tb_fak_ctrl
